// ===== logic/dec_axil_slave.sv
// axi4-lite slave front end: one write and one read in flight
module dec_axil_slave (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // write address and data
  input wire logic awvalid_i,
  output logic awready_o,
  input wire logic [7:0] awaddr_i,
  input wire logic wvalid_i,
  output logic wready_o,
  input wire logic [31:0] wdata_i,
  input wire logic [3:0] wstrb_i,
  // write response
  output logic bvalid_o,
  input wire logic bready_i,
  output logic [1:0] bresp_o,
  // read address and data
  input wire logic arvalid_i,
  output logic arready_o,
  input wire logic [7:0] araddr_i,
  output logic rvalid_o,
  input wire logic rready_i,
  output logic [31:0] rdata_o,
  output logic [1:0] rresp_o,
  // register file side
  output logic wr_en_o,
  output logic [7:0] wr_addr_o,
  output logic [31:0] wr_data_o,
  output logic [3:0] wr_strb_o,
  input wire logic wr_ok_i,
  output logic [7:0] rd_addr_o,
  input wire logic [31:0] rd_data_i,
  input wire logic rd_ok_i
);
  typedef struct packed {
    logic aw_full;
    logic w_full;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic ar_full;
    logic [7:0] araddr;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } dec_axil_state_t;

  dec_axil_state_t st_reg;
  dec_axil_state_t st_next;

  always_comb begin
    st_next = st_reg;
    if (st_reg.awready && awvalid_i) begin
      st_next.aw_full = 1'b1;
      st_next.awaddr = awaddr_i;
    end
    if (st_reg.wready && wvalid_i) begin
      st_next.w_full = 1'b1;
      st_next.wdata = wdata_i;
      st_next.wstrb = wstrb_i;
    end
    if (st_reg.bvalid && bready_i) begin
      st_next.bvalid = 1'b0;
    end
    if (wr_en_o) begin
      st_next.aw_full = 1'b0;
      st_next.w_full = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = wr_ok_i ? dec_pkg::RESP_OKAY : dec_pkg::RESP_SLVERR;
    end
    // ready drops while a response is pending, so one write at a time
    st_next.awready = !st_next.aw_full && !st_next.bvalid;
    st_next.wready = !st_next.w_full && !st_next.bvalid;
    if (st_reg.arready && arvalid_i) begin
      st_next.ar_full = 1'b1;
      st_next.araddr = araddr_i;
    end
    if (st_reg.rvalid && rready_i) begin
      st_next.rvalid = 1'b0;
    end
    if (st_reg.ar_full && !st_reg.rvalid) begin
      st_next.ar_full = 1'b0;
      st_next.rvalid = 1'b1;
      st_next.rdata = rd_data_i;
      st_next.rresp = rd_ok_i ? dec_pkg::RESP_OKAY : dec_pkg::RESP_SLVERR;
    end
    st_next.arready = !st_next.ar_full && !st_next.rvalid;
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign wr_en_o = st_reg.aw_full && st_reg.w_full && !st_reg.bvalid;
  assign wr_addr_o = st_reg.awaddr;
  assign wr_data_o = st_reg.wdata;
  assign wr_strb_o = st_reg.wstrb;
  assign rd_addr_o = st_reg.araddr;
  assign awready_o = st_reg.awready;
  assign wready_o = st_reg.wready;
  assign bvalid_o = st_reg.bvalid;
  assign bresp_o = st_reg.bresp;
  assign arready_o = st_reg.arready;
  assign rvalid_o = st_reg.rvalid;
  assign rdata_o = st_reg.rdata;
  assign rresp_o = st_reg.rresp;
endmodule

// ===== logic/dec_field_decode.sv
// decoders for the command code and the color depth field
module dec_field_decode (
  // fields
  input wire logic [3:0] code_i,
  input wire logic [1:0] depth_code_i,
  // decoded
  output dec_pkg::dec_cmd_t kind_o,
  output dec_pkg::dec_depth_t depth_o
);
  always_comb begin
    case (code_i)
      dec_pkg::CODE_BLT: kind_o = dec_pkg::DEC_CMD_BLT;
      dec_pkg::CODE_RECT_FILL: kind_o = dec_pkg::DEC_CMD_RECT_FILL;
      dec_pkg::CODE_TRAP_FILL: kind_o = dec_pkg::DEC_CMD_TRAP_FILL;
      dec_pkg::CODE_RLE_STRIP: kind_o = dec_pkg::DEC_CMD_RLE_STRIP;
      dec_pkg::CODE_SHORT_STROKE: kind_o = dec_pkg::DEC_CMD_SHORT_STROKE;
      dec_pkg::CODE_LINE: kind_o = dec_pkg::DEC_CMD_LINE;
      dec_pkg::CODE_HOST_WR: kind_o = dec_pkg::DEC_CMD_HOST_WR;
      dec_pkg::CODE_HOST_RD: kind_o = dec_pkg::DEC_CMD_HOST_RD;
      dec_pkg::CODE_HOST_WR_LB: kind_o = dec_pkg::DEC_CMD_HOST_WR_LB;
      dec_pkg::CODE_ROTATE: kind_o = dec_pkg::DEC_CMD_ROTATE;
      default: kind_o = dec_pkg::DEC_CMD_RESERVED;
    endcase
  end

  always_comb begin
    case (depth_code_i)
      dec_pkg::DEPTH_CODE_8: depth_o = dec_pkg::DEC_DEPTH_8;
      dec_pkg::DEPTH_CODE_16: depth_o = dec_pkg::DEC_DEPTH_16;
      dec_pkg::DEPTH_CODE_24: depth_o = dec_pkg::DEC_DEPTH_24;
      default: depth_o = dec_pkg::DEC_DEPTH_RESERVED;
    endcase
  end
endmodule

// ===== logic/dec_pkg.sv
// constants and types of the drawing engine command/control block
package dec_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int STRB_W = 4;
  localparam int REG_W = 16;
  localparam int PITCH_W = 12;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_DEST_X = 8'h04;
  localparam logic [7:0] IDX_DIM_X = 8'h0A;
  localparam logic [7:0] IDX_MISC = 8'h0C;
  localparam logic [7:0] IDX_CMD = 8'h0E;
  localparam logic [7:0] IDX_SRC_PITCH = 8'h10;
  localparam logic [7:0] IDX_DST_PITCH = 8'h12;
  localparam logic [7:0] IDX_FORMAT = 8'h1E;
  localparam logic [1:0] IDX_SHIFT_PAD = 2'h0;
  // command, misc, format and pitch register fields
  localparam int B_ACTIVATE = 15;
  localparam int B_PATTERN = 14;
  localparam int B_DEST_X_WB = 13;
  localparam int B_AUTO_START = 12;
  localparam int B_DIRECTION = 11;
  localparam int B_MAJOR_AXIS = 10;
  localparam int B_STEP_MSB = 9;
  localparam int B_STEP_LSB = 8;
  localparam int B_VSTRETCH = 7;
  localparam int B_HOST_FMT = 6;
  localparam int B_FINAL_PIX = 5;
  localparam int B_CAPTURE = 4;
  localparam int B_CMD_MSB = 3;
  localparam int B_CMD_LSB = 0;
  localparam int B_REPEAT_ROT = 11;
  localparam int B_DEPTH_MSB = 5;
  localparam int B_DEPTH_LSB = 4;
  localparam int B_PITCH_MSB = 11;
  // step field codes
  localparam logic [1:0] STEP_FLIP_RT_LB = 2'h0;
  localparam logic [1:0] STEP_LEFT_QTR = 2'h1;
  localparam logic [1:0] STEP_RIGHT_QTR = 2'h2;
  localparam logic [1:0] STEP_FLIP_LT_RB = 2'h3;
  // command codes
  localparam logic [3:0] CODE_BLT = 4'h0;
  localparam logic [3:0] CODE_RECT_FILL = 4'h1;
  localparam logic [3:0] CODE_TRAP_FILL = 4'h3;
  localparam logic [3:0] CODE_RLE_STRIP = 4'h5;
  localparam logic [3:0] CODE_SHORT_STROKE = 4'h6;
  localparam logic [3:0] CODE_LINE = 4'h7;
  localparam logic [3:0] CODE_HOST_WR = 4'h8;
  localparam logic [3:0] CODE_HOST_RD = 4'h9;
  localparam logic [3:0] CODE_HOST_WR_LB = 4'hA;
  localparam logic [3:0] CODE_ROTATE = 4'hB;
  // color depth codes and bus response codes
  localparam logic [1:0] DEPTH_CODE_8 = 2'h0;
  localparam logic [1:0] DEPTH_CODE_16 = 2'h1;
  localparam logic [1:0] DEPTH_CODE_24 = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [3:0] {
    DEC_CMD_BLT, DEC_CMD_RECT_FILL, DEC_CMD_TRAP_FILL, DEC_CMD_RLE_STRIP,
    DEC_CMD_SHORT_STROKE, DEC_CMD_LINE, DEC_CMD_HOST_WR, DEC_CMD_HOST_RD,
    DEC_CMD_HOST_WR_LB, DEC_CMD_ROTATE, DEC_CMD_RESERVED
  } dec_cmd_t;
  typedef enum logic [1:0] {
    DEC_DEPTH_8, DEC_DEPTH_16, DEC_DEPTH_24, DEC_DEPTH_RESERVED
  } dec_depth_t;
endpackage

// ===== logic/dec_top.sv
// drawing engine command/control register bank with axi4-lite access
//
// Function
// - activate and auto-start bits reset to zero
// - completion writes back destination X when enabled
// - auto-start activates engine on dimension X write
// - direction bit: stroke horizontal or blit leftward
// - major axis bit selects X or Y
// - step field decodes rotations and axis flips
// - stretch bit enables vertical-only stretching
// - host source format: color or monochrome
// - last-pixel bit draws or omits final pixel
// - capture bit enables host read capture
// - command codes 0, 1, 3, 5, 6, 7 decode to drawing functions, 2 and 4 to reserved
// - command codes 8 to B decode to host/rotation transfers, C to F to reserved
// - source pitch twelve bits, reserved bits above
// - destination pitch twelve bits, reserved bits above
// - repeat rotation counts only for rotation command
// - format field selects 8, 16, 24-bit color
module dec_top (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // axi4-lite write channels
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  output logic [1:0] s_axi_bresp_o,
  // axi4-lite read channels
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  input wire logic [7:0] s_axi_araddr_i,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  // pixel datapath status
  input wire logic engine_done_i,
  input wire logic [11:0] dest_x_adv_i,
  // engine control
  output logic engine_activate_o,
  output logic engine_start_o,
  output dec_pkg::dec_cmd_t cmd_kind_o,
  output logic cmd_reserved_o,
  // drawing options
  output logic pattern_kind_select_o,
  output logic dest_x_writeback_enable_o,
  output logic stroke_or_transfer_direction_o,
  output logic line_major_axis_o,
  output logic rotate_left_quarter_o,
  output logic rotate_right_quarter_o,
  output logic flip_rt_lb_o,
  output logic flip_lt_rb_o,
  output logic vertical_stretch_enable_o,
  output logic host_source_format_o,
  output logic final_pixel_draw_o,
  output logic host_read_capture_enable_o,
  output logic repeat_rotation_o,
  // geometry
  output logic [11:0] source_row_pitch_o,
  output logic [11:0] destination_row_pitch_o,
  output logic [11:0] dest_x_o,
  output logic [11:0] dim_x_o,
  output dec_pkg::dec_depth_t color_depth_o
);
  typedef struct packed {
    logic [15:0] cmd;
    logic [15:0] misc;
    logic [15:0] format;
    logic [11:0] src_pitch;
    logic [11:0] dst_pitch;
    logic [11:0] dest_x;
    logic [11:0] dim_x;
    logic start;
    dec_pkg::dec_cmd_t kind;
    logic rsvd;
    logic rot_left;
    logic rot_right;
    logic flip_rt_lb;
    logic flip_lt_rb;
    logic repeat_rot;
    dec_pkg::dec_depth_t depth;
  } dec_state_t;

  dec_state_t st_reg;
  dec_state_t st_next;

  logic wr_en;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_ok;
  logic [7:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_ok;
  logic [7:0] wr_idx;
  logic [7:0] rd_idx;
  dec_pkg::dec_cmd_t kind_dec;
  dec_pkg::dec_depth_t depth_dec;

  dec_axil_slave u_axil (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .awvalid_i(s_axi_awvalid_i),
    .awready_o(s_axi_awready_o),
    .awaddr_i(s_axi_awaddr_i),
    .wvalid_i(s_axi_wvalid_i),
    .wready_o(s_axi_wready_o),
    .wdata_i(s_axi_wdata_i),
    .wstrb_i(s_axi_wstrb_i),
    .bvalid_o(s_axi_bvalid_o),
    .bready_i(s_axi_bready_i),
    .bresp_o(s_axi_bresp_o),
    .arvalid_i(s_axi_arvalid_i),
    .arready_o(s_axi_arready_o),
    .araddr_i(s_axi_araddr_i),
    .rvalid_o(s_axi_rvalid_o),
    .rready_i(s_axi_rready_i),
    .rdata_o(s_axi_rdata_o),
    .rresp_o(s_axi_rresp_o),
    .wr_en_o(wr_en),
    .wr_addr_o(wr_addr),
    .wr_data_o(wr_data),
    .wr_strb_o(wr_strb),
    .wr_ok_i(wr_ok),
    .rd_addr_o(rd_addr),
    .rd_data_i(rd_data),
    .rd_ok_i(rd_ok)
  );

  // decoded from the stored fields; results land one cycle later
  dec_field_decode u_decode (
    .code_i(st_reg.cmd[dec_pkg::B_CMD_MSB:dec_pkg::B_CMD_LSB]),
    .depth_code_i(
      st_reg.format[dec_pkg::B_DEPTH_MSB:dec_pkg::B_DEPTH_LSB]),
    .kind_o(kind_dec),
    .depth_o(depth_dec)
  );

  // byte-lane merge of a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                          input logic [31:0] data,
                                          input logic [3:0] strb);
    logic [15:0] res;
    res = old_v;
    for (int b = 0; b < 2; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = data[b*8 +: 8];
      end
    end
    return res;
  endfunction

  assign wr_idx = {dec_pkg::IDX_SHIFT_PAD, wr_addr[7:2]};
  assign rd_idx = {dec_pkg::IDX_SHIFT_PAD, rd_addr[7:2]};

  always_comb begin
    if (wr_idx == dec_pkg::IDX_DEST_X) begin
      wr_ok = 1'b1;
    end else if (wr_idx == dec_pkg::IDX_DIM_X) begin
      wr_ok = 1'b1;
    end else if (wr_idx == dec_pkg::IDX_MISC) begin
      wr_ok = 1'b1;
    end else if (wr_idx == dec_pkg::IDX_CMD) begin
      wr_ok = 1'b1;
    end else if (wr_idx == dec_pkg::IDX_SRC_PITCH) begin
      wr_ok = 1'b1;
    end else if (wr_idx == dec_pkg::IDX_DST_PITCH) begin
      wr_ok = 1'b1;
    end else if (wr_idx == dec_pkg::IDX_FORMAT) begin
      wr_ok = 1'b1;
    end else begin
      wr_ok = 1'b0;
    end
  end

  // reserved pitch bits are zero-filled on read
  always_comb begin
    rd_data = '0;
    rd_ok = 1'b1;
    if (rd_idx == dec_pkg::IDX_DEST_X) begin
      rd_data[dec_pkg::PITCH_W-1:0] = st_reg.dest_x;
    end else if (rd_idx == dec_pkg::IDX_DIM_X) begin
      rd_data[dec_pkg::PITCH_W-1:0] = st_reg.dim_x;
    end else if (rd_idx == dec_pkg::IDX_MISC) begin
      rd_data[dec_pkg::REG_W-1:0] = st_reg.misc;
    end else if (rd_idx == dec_pkg::IDX_CMD) begin
      rd_data[dec_pkg::REG_W-1:0] = st_reg.cmd;
    end else if (rd_idx == dec_pkg::IDX_SRC_PITCH) begin
      rd_data[dec_pkg::PITCH_W-1:0] = st_reg.src_pitch;
    end else if (rd_idx == dec_pkg::IDX_DST_PITCH) begin
      rd_data[dec_pkg::PITCH_W-1:0] = st_reg.dst_pitch;
    end else if (rd_idx == dec_pkg::IDX_FORMAT) begin
      rd_data[dec_pkg::REG_W-1:0] = st_reg.format;
    end else begin
      rd_ok = 1'b0;
    end
  end

  always_comb begin
    logic [15:0] tmp;
    logic set_act;
    tmp = '0;
    set_act = 1'b0;
    st_next = st_reg;
    st_next.start = 1'b0;
    if (wr_en && wr_idx == dec_pkg::IDX_CMD) begin
      st_next.cmd = merge16(st_reg.cmd, wr_data, wr_strb);
      set_act = wr_strb[1] && wr_data[dec_pkg::B_ACTIVATE];
    end
    if (wr_en && wr_idx == dec_pkg::IDX_MISC) begin
      st_next.misc = merge16(st_reg.misc, wr_data, wr_strb);
    end
    if (wr_en && wr_idx == dec_pkg::IDX_FORMAT) begin
      st_next.format = merge16(st_reg.format, wr_data, wr_strb);
    end
    // upper nibble of the pitches is dropped on write
    if (wr_en && wr_idx == dec_pkg::IDX_SRC_PITCH) begin
      tmp = merge16({4'h0, st_reg.src_pitch}, wr_data, wr_strb);
      st_next.src_pitch = tmp[dec_pkg::B_PITCH_MSB:0];
    end
    if (wr_en && wr_idx == dec_pkg::IDX_DST_PITCH) begin
      tmp = merge16({4'h0, st_reg.dst_pitch}, wr_data, wr_strb);
      st_next.dst_pitch = tmp[dec_pkg::B_PITCH_MSB:0];
    end
    if (wr_en && wr_idx == dec_pkg::IDX_DEST_X) begin
      tmp = merge16({4'h0, st_reg.dest_x}, wr_data, wr_strb);
      st_next.dest_x = tmp[dec_pkg::B_PITCH_MSB:0];
    end
    if (wr_en && wr_idx == dec_pkg::IDX_DIM_X) begin
      tmp = merge16({4'h0, st_reg.dim_x}, wr_data, wr_strb);
      st_next.dim_x = tmp[dec_pkg::B_PITCH_MSB:0];
      // software need not touch the activate bit here
      if (st_reg.cmd[dec_pkg::B_AUTO_START]) begin
        set_act = 1'b1;
      end
    end
    // completion: written-back dest_x overrides a same-cycle software write
    if (engine_done_i && st_reg.cmd[dec_pkg::B_ACTIVATE]) begin
      st_next.cmd[dec_pkg::B_ACTIVATE] = 1'b0;
      if (st_reg.cmd[dec_pkg::B_DEST_X_WB]) begin
        st_next.dest_x = dest_x_adv_i;
      end
    end
    // a start request beats a same-cycle completion
    if (set_act) begin
      st_next.cmd[dec_pkg::B_ACTIVATE] = 1'b1;
      st_next.start = 1'b1;
    end
    st_next.kind = kind_dec;
    st_next.rsvd = (kind_dec == dec_pkg::DEC_CMD_RESERVED);
    st_next.depth = depth_dec;
    // the repeat flag is meaningless outside rotation transfers
    st_next.repeat_rot = st_reg.misc[dec_pkg::B_REPEAT_ROT]
      && (kind_dec == dec_pkg::DEC_CMD_ROTATE);
    st_next.rot_left = 1'b0;
    st_next.rot_right = 1'b0;
    st_next.flip_rt_lb = 1'b0;
    st_next.flip_lt_rb = 1'b0;
    case (st_reg.cmd[dec_pkg::B_STEP_MSB:dec_pkg::B_STEP_LSB])
      dec_pkg::STEP_LEFT_QTR: st_next.rot_left = 1'b1;
      dec_pkg::STEP_RIGHT_QTR: st_next.rot_right = 1'b1;
      dec_pkg::STEP_FLIP_RT_LB: st_next.flip_rt_lb = 1'b1;
      default: st_next.flip_lt_rb = 1'b1;
    endcase
  end

  // every field cleared at reset, which covers the two required bits
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign engine_activate_o = st_reg.cmd[dec_pkg::B_ACTIVATE];
  assign engine_start_o = st_reg.start;
  assign cmd_kind_o = st_reg.kind;
  assign cmd_reserved_o = st_reg.rsvd;
  assign pattern_kind_select_o = st_reg.cmd[dec_pkg::B_PATTERN];
  assign dest_x_writeback_enable_o = st_reg.cmd[dec_pkg::B_DEST_X_WB];
  assign stroke_or_transfer_direction_o =
    st_reg.cmd[dec_pkg::B_DIRECTION];
  assign line_major_axis_o = st_reg.cmd[dec_pkg::B_MAJOR_AXIS];
  assign rotate_left_quarter_o = st_reg.rot_left;
  assign rotate_right_quarter_o = st_reg.rot_right;
  assign flip_rt_lb_o = st_reg.flip_rt_lb;
  assign flip_lt_rb_o = st_reg.flip_lt_rb;
  assign vertical_stretch_enable_o =
    st_reg.cmd[dec_pkg::B_VSTRETCH];
  assign host_source_format_o = st_reg.cmd[dec_pkg::B_HOST_FMT];
  assign final_pixel_draw_o = st_reg.cmd[dec_pkg::B_FINAL_PIX];
  assign host_read_capture_enable_o =
    st_reg.cmd[dec_pkg::B_CAPTURE];
  assign repeat_rotation_o = st_reg.repeat_rot;
  assign source_row_pitch_o = st_reg.src_pitch;
  assign destination_row_pitch_o = st_reg.dst_pitch;
  assign dest_x_o = st_reg.dest_x;
  assign dim_x_o = st_reg.dim_x;
  assign color_depth_o = st_reg.depth;
endmodule

// ===== sim/dec_top_monitor.sv
// concurrent checks on the command/control register bank ports
module dec_top_monitor (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // datapath status
  input wire logic engine_done_i,
  input wire logic [11:0] dest_x_adv_i,
  // bus responses
  input wire logic s_axi_rvalid_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic s_axi_bvalid_o,
  // engine outputs
  input wire logic engine_activate_o,
  input wire logic engine_start_o,
  input wire dec_pkg::dec_cmd_t cmd_kind_o,
  input wire logic cmd_reserved_o,
  input wire logic dest_x_writeback_enable_o,
  input wire logic rotate_left_quarter_o,
  input wire logic rotate_right_quarter_o,
  input wire logic flip_rt_lb_o,
  input wire logic flip_lt_rb_o,
  input wire logic repeat_rotation_o,
  input wire logic [11:0] dest_x_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  // completion only counts while the engine is busy
  sequence done_seen;
    engine_done_i && engine_activate_o;
  endsequence
  act_reset_a: assert property (
    $fell(sys_rst_i) |-> !engine_activate_o && !engine_start_o)
    else $error("busy after reset");
  start_active_a: assert property (
    engine_start_o |-> engine_activate_o)
    else $error("start without busy");
  start_pulse_a: assert property (
    engine_start_o |=> !engine_start_o)
    else $error("start pulse too long");
  done_clear_a: assert property (
    done_seen |=> !engine_activate_o || engine_start_o)
    else $error("busy kept after completion");
  dx_update_a: assert property (
    done_seen and dest_x_writeback_enable_o
      |=> dest_x_o == $past(dest_x_adv_i))
    else $error("dest x not updated");
  dx_hold_a: assert property (
    done_seen and !dest_x_writeback_enable_o
      |=> $stable(dest_x_o) || $rose(s_axi_bvalid_o))
    else $error("dest x changed");
  step_onehot_a: assert property (
    !$past(sys_rst_i) |-> $onehot({rotate_left_quarter_o,
      rotate_right_quarter_o, flip_rt_lb_o, flip_lt_rb_o}))
    else $error("step decode not one-hot");
  rot_repeat_a: assert property (
    repeat_rotation_o |-> cmd_kind_o == dec_pkg::DEC_CMD_ROTATE)
    else $error("repeat outside rotation");
  kind_reserved_a: assert property (
    cmd_reserved_o |-> cmd_kind_o == dec_pkg::DEC_CMD_RESERVED)
    else $error("reserved flag mismatch");
  rdata_upper_a: assert property (
    s_axi_rvalid_o |-> s_axi_rdata_o[31:16] == 16'h0000)
    else $error("upper read bits set");
endmodule

bind dec_top dec_top_monitor u_mon (.*);

// ===== sim/tb.sv
// self-checking bench for the command/control register bank
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [7:0] A_CMD = 8'h38;
  localparam logic [1:0] OK = dec_pkg::RESP_OKAY;
  logic clk_sys_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic s_axi_awvalid_i, s_axi_awready_o, s_axi_wvalid_i, s_axi_wready_o;
  logic s_axi_bvalid_o, s_axi_bready_i, s_axi_arvalid_i, s_axi_arready_o;
  logic s_axi_rvalid_o, s_axi_rready_i, engine_done_i, wr_start;
  logic [7:0] s_axi_awaddr_i, s_axi_araddr_i;
  logic [31:0] s_axi_wdata_i, s_axi_rdata_o;
  logic [3:0] s_axi_wstrb_i;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
  logic [11:0] dest_x_adv_i, source_row_pitch_o, destination_row_pitch_o;
  logic [11:0] dest_x_o, dim_x_o;
  logic engine_activate_o, engine_start_o, cmd_reserved_o;
  logic pattern_kind_select_o, dest_x_writeback_enable_o;
  logic stroke_or_transfer_direction_o, line_major_axis_o;
  logic rotate_left_quarter_o, rotate_right_quarter_o;
  logic flip_rt_lb_o, flip_lt_rb_o, vertical_stretch_enable_o;
  logic host_source_format_o, final_pixel_draw_o;
  logic host_read_capture_enable_o, repeat_rotation_o;
  dec_pkg::dec_cmd_t cmd_kind_o;
  dec_pkg::dec_depth_t color_depth_o;
  int miscompares = 0;
  int num_checks = 0;

  dec_top DUT (.*);

  always #12.5 clk_sys_i = ~clk_sys_i;

  task automatic chk(input string nm, input logic [31:0] seen,
      input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask

  // leading edge keeps bready/rready from being set twice in one step
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
      input logic [3:0] s, input logic [1:0] er);
    @(posedge clk_sys_i);
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= d;
    s_axi_wstrb_i <= s;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    s_axi_bready_i <= 1'b1;
    do begin
      @(posedge clk_sys_i);
      if (s_axi_awvalid_i && s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
      if (s_axi_wvalid_i && s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
    end while (!s_axi_bvalid_o);
    wr_start = engine_start_o;
    s_axi_bready_i <= 1'b0;
    chk("bresp", s_axi_bresp_o, er);
  endtask

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed,
      input logic [1:0] er);
    @(posedge clk_sys_i);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i <= 1'b1;
    do begin
      @(posedge clk_sys_i);
      if (s_axi_arvalid_i && s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
    end while (!s_axi_rvalid_o);
    s_axi_rready_i <= 1'b0;
    chk("rdata", s_axi_rdata_o, ed);
    chk("rresp", s_axi_rresp_o, er);
  endtask

  task automatic pulse_done(input logic [11:0] x);
    @(posedge clk_sys_i);
    engine_done_i <= 1'b1;
    dest_x_adv_i <= x;
    @(posedge clk_sys_i);
    engine_done_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask

  task automatic t_options();
    logic [15:0] p [2] = '{16'h4850, 16'h24A0};
    foreach (p[i]) begin
      axi_wr(A_CMD, {16'h0, p[i]}, 4'hF, OK);
      chk("options", {pattern_kind_select_o, dest_x_writeback_enable_o,
          stroke_or_transfer_direction_o, line_major_axis_o,
          vertical_stretch_enable_o, host_source_format_o,
          final_pixel_draw_o, host_read_capture_enable_o},
          {p[i][14:13], p[i][11:10], p[i][7:4]});
      axi_rd(A_CMD, {16'h0, p[i]}, OK);
    end
  endtask

  task automatic t_codes();
    dec_pkg::dec_cmd_t k [16] = '{dec_pkg::DEC_CMD_BLT,
      dec_pkg::DEC_CMD_RECT_FILL, dec_pkg::DEC_CMD_RESERVED,
      dec_pkg::DEC_CMD_TRAP_FILL, dec_pkg::DEC_CMD_RESERVED,
      dec_pkg::DEC_CMD_RLE_STRIP, dec_pkg::DEC_CMD_SHORT_STROKE,
      dec_pkg::DEC_CMD_LINE, dec_pkg::DEC_CMD_HOST_WR,
      dec_pkg::DEC_CMD_HOST_RD, dec_pkg::DEC_CMD_HOST_WR_LB,
      dec_pkg::DEC_CMD_ROTATE, dec_pkg::DEC_CMD_RESERVED,
      dec_pkg::DEC_CMD_RESERVED, dec_pkg::DEC_CMD_RESERVED,
      dec_pkg::DEC_CMD_RESERVED};
    for (int c = 0; c < 16; c++) begin
      axi_wr(A_CMD, {22'h0, c[1:0], 4'h0, c[3:0]}, 4'hF, OK);
      @(posedge clk_sys_i);
      chk("kind", cmd_kind_o, k[c]);
      chk("reserved", cmd_reserved_o,
          k[c] == dec_pkg::DEC_CMD_RESERVED);
      chk("step", {rotate_left_quarter_o, rotate_right_quarter_o,
          flip_rt_lb_o, flip_lt_rb_o}, {c[1:0] == 2'h1, c[1:0] == 2'h2,
          c[1:0] == 2'h0, c[1:0] == 2'h3});
    end
  endtask

  task automatic t_misc();
    dec_pkg::dec_depth_t dp [4] = '{dec_pkg::DEC_DEPTH_8,
      dec_pkg::DEC_DEPTH_16, dec_pkg::DEC_DEPTH_RESERVED,
      dec_pkg::DEC_DEPTH_24};
    axi_wr(8'h30, 32'h0000_0800, 4'hF, OK);
    axi_wr(A_CMD, 32'h0000_000B, 4'hF, OK);
    @(posedge clk_sys_i);
    chk("repeat", repeat_rotation_o, 1'b1);
    axi_wr(A_CMD, 32'h0000_000A, 4'hF, OK);
    @(posedge clk_sys_i);
    chk("repeat", repeat_rotation_o, 1'b0);
    for (int i = 0; i < 4; i++) begin
      axi_wr(8'h78, {26'h0, i[1:0], 4'h0}, 4'hF, OK);
      @(posedge clk_sys_i);
      chk("depth", color_depth_o, dp[i]);
    end
  endtask

  task automatic t_pitch();
    axi_wr(8'h40, 32'hFFFF_FABC, 4'hF, OK);
    chk("src pitch", source_row_pitch_o, 12'hABC);
    axi_rd(8'h40, 32'h0000_0ABC, OK);
    axi_wr(8'h48, 32'h0000_F345, 4'hF, OK);
    // only the low byte lane may land
    axi_wr(8'h48, 32'h0000_56E2, 4'h1, OK);
    chk("dst pitch", destination_row_pitch_o, 12'h3E2);
    axi_rd(8'h48, 32'h0000_03E2, OK);
    axi_wr(8'hFC, 32'h0000_FFFF, 4'hF, dec_pkg::RESP_SLVERR);
    axi_rd(8'hFC, 32'h0, dec_pkg::RESP_SLVERR);
  endtask

  task automatic t_engine();
    axi_wr(8'h10, 32'h0000_0111, 4'hF, OK);
    axi_wr(A_CMD, 32'h0000_A000, 4'hF, OK);
    chk("start", wr_start, 1'b1);
    chk("activate", engine_activate_o, 1'b1);
    pulse_done(12'h5A5);
    chk("activate", engine_activate_o, 1'b0);
    chk("dest x", dest_x_o, 12'h5A5);
    axi_wr(A_CMD, 32'h0000_1000, 4'hF, OK);
    chk("start", wr_start, 1'b0);
    axi_wr(8'h28, 32'h0000_F123, 4'hF, OK);
    chk("start", wr_start, 1'b1);
    chk("activate", engine_activate_o, 1'b1);
    chk("dim x", dim_x_o, 12'h123);
    pulse_done(12'h777);
    chk("dest x", dest_x_o, 12'h5A5);
    chk("activate", engine_activate_o, 1'b0);
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    s_axi_awvalid_i = 1'b0;
    s_axi_wvalid_i = 1'b0;
    s_axi_bready_i = 1'b0;
    s_axi_arvalid_i = 1'b0;
    s_axi_rready_i = 1'b0;
    s_axi_awaddr_i = 8'h00;
    s_axi_araddr_i = 8'h00;
    s_axi_wdata_i = 32'h0;
    s_axi_wstrb_i = 4'h0;
    engine_done_i = 1'b0;
    dest_x_adv_i = 12'h000;
    repeat (4) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_sys_i);
    chk("activate", engine_activate_o, 1'b0);
    chk("start", engine_start_o, 1'b0);
    t_options();
    t_codes();
    t_misc();
    t_pitch();
    t_engine();
    end_sim();
  end

  // whole run is a few hundred bus cycles
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    miscompares++;
    end_sim();
  end
endmodule
